// file: logic/byte_alu_defines.vh
// Purpose: constants for the byte alu and bit-op block
// Assumes: 32-bit apb, word aligned registers
// Notes: offsets are byte addresses
`ifndef BYTE_ALU_DEFINES_VH
`define BYTE_ALU_DEFINES_VH

// register offsets
`define OFS_OPERAND 12'h000
`define OFS_COMMAND 12'h004
`define OFS_ACC 12'h008
`define OFS_STATUS 12'h00c
`define OFS_PORT_LATCH 12'h010
`define FILE_WIN_TAG 3'h1

// operand register fields
`define OPR_LIT_LSB 0
`define OPR_ADDR_LSB 8
`define OPR_BIT_LSB 15
`define OPR_DEST_BIT 18

// status register fields
`define ST_CARRY 0
`define ST_DIGIT 1
`define ST_ZERO 2

// command codes
`define OP_NONE 3'h0
`define OP_ADD_LIT 3'h1
`define OP_AND_LIT 3'h2
`define OP_ADD_REG 3'h3
`define OP_AND_REG 3'h4
`define OP_BIT_CLR 3'h5
`define OP_BIT_SET 3'h6

// file register holding the io port
`define PORT_FILE_ADDR 7'h06

// reset values
`define RST_BYTE 8'h00
`define RST_OPERAND 19'h0_0000

`endif

// file: logic/alu_core.v
// Purpose: combinational 8-bit arithmetic, logic and bit ops
// Assumes: operands already selected by the caller
// Notes: flag update enables tell the caller which flags change
`timescale 1ns/100ps
`include "byte_alu_defines.vh"

module alu_core (
    // command
    input wire [2:0] op,
    input wire [2:0] bit_idx,
    // operands
    input wire [7:0] acc,
    input wire [7:0] opnd,
    // result and flags
    output reg [7:0] result,
    output reg carry,
    output reg digit_carry,
    output reg zero,
    output reg upd_arith,
    output reg upd_zero
);

    function [8:0] add_bytes;
        input [7:0] a;
        input [7:0] b;
        begin
            add_bytes = {1'b0, a} + {1'b0, b};
        end
    endfunction

    function [4:0] add_nibbles;
        input [3:0] a;
        input [3:0] b;
        begin
            add_nibbles = {1'b0, a} + {1'b0, b};
        end
    endfunction

    reg [8:0] sum;
    reg [4:0] low_sum;
    reg [7:0] bit_mask;

    always @* begin
        sum = add_bytes(acc, opnd);
        low_sum = add_nibbles(acc[3:0], opnd[3:0]);
        bit_mask = 8'h01 << bit_idx;
        result = opnd;
        upd_arith = 1'b0;
        upd_zero = 1'b0;
        case (op)
            `OP_ADD_LIT, `OP_ADD_REG: begin
                result = sum[7:0];
                upd_arith = 1'b1;
                upd_zero = 1'b1;
            end
            `OP_AND_LIT, `OP_AND_REG: begin
                result = acc & opnd;
                upd_zero = 1'b1;
            end
            `OP_BIT_CLR: begin
                result = opnd & ~bit_mask;
            end
            `OP_BIT_SET: begin
                result = opnd | bit_mask;
            end
            default: begin
                result = opnd;
            end
        endcase
        carry = sum[8];
        digit_carry = low_sum[4];
        zero = (result == 8'h00);
    end

endmodule // alu_core

// file: logic/byte_alu_bit_ops.v
// Purpose: byte alu and bit ops on accumulator and file registers
// Assumes: apb slave, zero wait states, one clock
// Notes: a command write executes in the cycle it is accepted
`timescale 1ns/100ps
`include "byte_alu_defines.vh"

// Functional notes
// - add literal to accumulator, flags C DC Z
// - and literal into accumulator, zero only
// - add accumulator and file register, flags
// - add result goes to acc or register
// - and with register, only zero changes
// - and result goes to acc or register
// - clear selected bit, no flags change
// - set selected bit, no flags change
// - port register reads pins, not latch
module byte_alu_bit_ops (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // io port
    input wire [7:0] port_pins,
    output reg [7:0] port_latch_q,
    // core state
    output reg [7:0] acc_q,
    output reg carry_flag_q,
    output reg digit_carry_flag_q,
    output reg zero_flag_q
);

    reg [7:0] file_mem [0:127];
    reg [18:0] operand_q;
    reg [31:0] rd_data;
    reg rd_hit;
    wire setup_phase;
    wire access_wr;
    wire in_file_win;
    wire [6:0] win_addr;
    wire [6:0] op_addr;
    wire [2:0] op_bit;
    wire op_dest;
    wire [7:0] op_lit;
    wire [2:0] cmd;
    wire is_reg_op;
    wire [7:0] reg_value;
    wire [7:0] alu_opnd;
    wire [7:0] alu_result;
    wire alu_carry;
    wire alu_digit;
    wire alu_zero;
    wire upd_arith;
    wire upd_zero;
    wire exec;
    wire to_file;
    // next values of the control registers
    reg [18:0] operand_d;
    reg [7:0] acc_d;
    reg [7:0] port_latch_d;
    reg carry_flag_d;
    reg digit_carry_flag_d;
    reg zero_flag_d;
    reg [31:0] prdata_d;

    function [7:0] file_read;
        input [6:0] addr;
        input [7:0] pins;
        input [7:0] word;
        begin
            if (addr == `PORT_FILE_ADDR) begin
                file_read = pins;
            end else begin
                file_read = word;
            end
        end
    endfunction

    assign setup_phase = psel & ~penable;
    assign access_wr = psel & penable & pwrite;
    assign in_file_win = (paddr[11:9] == `FILE_WIN_TAG);
    assign win_addr = paddr[8:2];
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~rd_hit;

    assign op_lit = operand_q[`OPR_LIT_LSB +: 8];
    assign op_addr = operand_q[`OPR_ADDR_LSB +: 7];
    assign op_bit = operand_q[`OPR_BIT_LSB +: 3];
    assign op_dest = operand_q[`OPR_DEST_BIT];
    assign cmd = pwdata[2:0];
    assign exec = access_wr & (paddr == `OFS_COMMAND);

    assign is_reg_op = (cmd == `OP_ADD_REG) || (cmd == `OP_AND_REG) ||
        (cmd == `OP_BIT_CLR) || (cmd == `OP_BIT_SET);
    assign reg_value = file_read(op_addr, port_pins, file_mem[op_addr]);
    assign alu_opnd = is_reg_op ? reg_value : op_lit;
    assign to_file = ((cmd == `OP_ADD_REG) && op_dest) ||
        ((cmd == `OP_AND_REG) && op_dest) ||
        (cmd == `OP_BIT_CLR) || (cmd == `OP_BIT_SET);

    alu_core u_alu (
        .op(cmd),
        .bit_idx(op_bit),
        .acc(acc_q),
        .opnd(alu_opnd),
        .result(alu_result),
        .carry(alu_carry),
        .digit_carry(alu_digit),
        .zero(alu_zero),
        .upd_arith(upd_arith),
        .upd_zero(upd_zero)
    );

    // read decode
    always @* begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        if (in_file_win) begin
            rd_data = {24'h00_0000, file_read(win_addr, port_pins, file_mem[win_addr])};
        end else begin
            case (paddr)
                `OFS_OPERAND: rd_data = {13'h0000, operand_q};
                `OFS_COMMAND: rd_data = 32'h0000_0000;
                `OFS_ACC: rd_data = {24'h00_0000, acc_q};
                `OFS_STATUS: rd_data = {29'h0000_0000, zero_flag_q,
                    digit_carry_flag_q, carry_flag_q};
                `OFS_PORT_LATCH: rd_data = {24'h00_0000, port_latch_q};
                default: rd_hit = 1'b0;
            endcase
        end
    end

    // read data captured in the setup cycle
    always @* begin
        prdata_d = prdata;
        if (setup_phase) begin
            prdata_d = rd_hit ? rd_data : 32'h0000_0000;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= prdata_d;
        end
    end

    // next state of control registers and execution
    always @* begin
        operand_d = operand_q;
        acc_d = acc_q;
        port_latch_d = port_latch_q;
        carry_flag_d = carry_flag_q;
        digit_carry_flag_d = digit_carry_flag_q;
        zero_flag_d = zero_flag_q;
        if (exec) begin
            if (!to_file && (cmd != `OP_NONE) && (cmd != 3'h7)) begin
                acc_d = alu_result;
            end
            if (to_file && (op_addr == `PORT_FILE_ADDR)) begin
                port_latch_d = alu_result;
            end
            if (upd_arith) begin
                carry_flag_d = alu_carry;
                digit_carry_flag_d = alu_digit;
            end
            if (upd_zero) begin
                zero_flag_d = alu_zero;
            end
        end else if (access_wr && in_file_win) begin
            // port slot of the window writes the latch
            if (win_addr == `PORT_FILE_ADDR) begin
                port_latch_d = pwdata[7:0];
            end
        end else if (access_wr) begin
            case (paddr)
                `OFS_OPERAND: operand_d = pwdata[18:0];
                `OFS_ACC: acc_d = pwdata[7:0];
                `OFS_STATUS: begin
                    carry_flag_d = pwdata[`ST_CARRY];
                    digit_carry_flag_d = pwdata[`ST_DIGIT];
                    zero_flag_d = pwdata[`ST_ZERO];
                end
                `OFS_PORT_LATCH: port_latch_d = pwdata[7:0];
                default: operand_d = operand_q;
            endcase
        end
    end

    // control registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            operand_q <= `RST_OPERAND;
            acc_q <= `RST_BYTE;
            carry_flag_q <= 1'b0;
            digit_carry_flag_q <= 1'b0;
            zero_flag_q <= 1'b0;
            port_latch_q <= `RST_BYTE;
        end else begin
            operand_q <= operand_d;
            acc_q <= acc_d;
            carry_flag_q <= carry_flag_d;
            digit_carry_flag_q <= digit_carry_flag_d;
            zero_flag_q <= zero_flag_d;
            port_latch_q <= port_latch_d;
        end
    end

    // file register array
    always @(posedge clk) begin
        if (exec && to_file && (op_addr != `PORT_FILE_ADDR)) begin
            file_mem[op_addr] <= alu_result;
        end else if (access_wr && in_file_win && (win_addr != `PORT_FILE_ADDR)) begin
            file_mem[win_addr] <= pwdata[7:0];
        end
    end

endmodule // byte_alu_bit_ops

// file: tb/byte_alu_monitor.sv
// Purpose: port checks for the byte alu
// Assumes: a command acts at its access edge
// Notes: results judged one cycle later
`timescale 1ns/100ps
`include "byte_alu_defines.vh"
module byte_alu_monitor (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    // state
    input wire [7:0] acc_q,
    input wire carry_flag_q,
    input wire digit_carry_flag_q,
    input wire zero_flag_q
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    wire wr = psel && penable && pwrite;
    wire cmd = wr && paddr == `OFS_COMMAND;
    wire [2:0] op = pwdata[2:0];
    reg [7:0] lit_q;
    reg dest_q;
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lit_q <= 8'h00;
            dest_q <= 1'b0;
        end else if (wr && paddr == `OFS_OPERAND) begin
            lit_q <= pwdata[7:0];
            dest_q <= pwdata[18];
        end
    end
    a_add_lit_sum: assert property (
        cmd && op == `OP_ADD_LIT |=> {carry_flag_q, acc_q} == $past(acc_q) + $past(lit_q)
        && digit_carry_flag_q == ({1'b0, $past(acc_q[3:0])} + $past(lit_q[3:0]) > 5'h0f)
        && zero_flag_q == (acc_q == 8'h00)) else $error("add literal wrong");
    a_and_lit_zero: assert property (
        cmd && op == `OP_AND_LIT |=> $stable(carry_flag_q) && $stable(digit_carry_flag_q)
        && acc_q == ($past(acc_q) & $past(lit_q)) && zero_flag_q == (acc_q == 8'h00))
        else $error("and literal wrong");
    a_add_reg_dest: assert property (
        cmd && op == `OP_ADD_REG |=> (dest_q ? $stable(acc_q) : zero_flag_q == (acc_q == 8'h00)))
        else $error("add register zero wrong");
    a_and_reg_keep: assert property (
        cmd && op == `OP_AND_REG |=> $stable(carry_flag_q) && $stable(digit_carry_flag_q)
        && (acc_q & ~$past(acc_q)) == 8'h00 && (!dest_q || $stable(acc_q)))
        else $error("and register wrong");
    a_bit_clr_keep: assert property (
        cmd && op == `OP_BIT_CLR |=> $stable({acc_q, carry_flag_q, digit_carry_flag_q,
        zero_flag_q})) else $error("bit clear touched state");
    a_bit_set_keep: assert property (
        cmd && op == `OP_BIT_SET |=> $stable({acc_q, carry_flag_q, digit_carry_flag_q,
        zero_flag_q})) else $error("bit set touched state");
    a_idle_acc_hold: assert property (!psel |=> $stable(acc_q))
        else $error("acc moved while idle");
    a_bad_addr_err: assert property (psel && penable && paddr == 12'h014 |-> pslverr)
        else $error("no error on unmapped");
    a_good_addr_ok: assert property (psel && penable && paddr == `OFS_ACC |-> !pslverr)
        else $error("error on mapped");
endmodule // byte_alu_monitor
bind byte_alu_bit_ops byte_alu_monitor i_byte_alu_monitor (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .acc_q(acc_q),
    .carry_flag_q(carry_flag_q), .digit_carry_flag_q(digit_carry_flag_q),
    .zero_flag_q(zero_flag_q));

// file: tb/test_byte_alu_bit_ops.sv
// Purpose: self-checking bench for the byte alu
// Assumes: zero wait apb
// Notes: model kept in plain variables
`timescale 1ns/100ps
`include "byte_alu_defines.vh"
module test_byte_alu_bit_ops;
    reg clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, c = 0, dc = 0, z = 0, se;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd, lf = 32'ha6bc_66a4;
    reg [7:0] port_pins = 0, acc = 0, lat = 0, f, x, res, m [0:127];
    reg [8:0] s;
    wire [31:0] prdata;
    wire [7:0] port_latch_q, acc_q;
    wire pready, pslverr, cf, dcf, zf;
    integer failures = 0, checks_done = 0, cyc = 0, i;
    byte_alu_bit_ops i_byte_alu_bit_ops (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_pins(port_pins),
        .port_latch_q(port_latch_q), .acc_q(acc_q), .carry_flag_q(cf),
        .digit_carry_flag_q(dcf), .zero_flag_q(zf));
    always #4 clk = ~clk;
    function [31:0] nx(input [31:0] v);
        nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task complete_run;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            complete_run;
        end
    end
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("BAD %0s exp %h got %h", n, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            rd = prdata;
            se = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask
    task exec(input [2:0] op, input [18:0] o);
        begin
            @(posedge clk);
            port_pins <= lf[23:16];
            apb(1, `OFS_OPERAND, {13'h0000, o});
            apb(1, `OFS_COMMAND, {29'h0000_0000, op});
            f = (o[14:8] == `PORT_FILE_ADDR) ? port_pins : m[o[14:8]];
            x = (op <= `OP_AND_LIT) ? o[7:0] : f;
            s = acc + x;
            res = (op == `OP_ADD_LIT || op == `OP_ADD_REG) ? s[7:0] : acc & x;
            if (op == `OP_BIT_CLR) res = f & ~(8'h01 << o[17:15]);
            if (op == `OP_BIT_SET) res = f | (8'h01 << o[17:15]);
            if (op == `OP_ADD_LIT || op == `OP_ADD_REG) begin
                c = s[8];
                dc = (acc[3:0] + x[3:0]) > 15;
            end
            if (op < `OP_BIT_CLR) z = (res == 8'h00);
            if (op <= `OP_AND_LIT || (op <= `OP_AND_REG && !o[18])) acc = res;
            else if (o[14:8] == `PORT_FILE_ADDR) lat = res;
            else m[o[14:8]] = res;
            #1;
            chk("acc", acc, acc_q);
            chk("flags", {c, dc, z}, {cf, dcf, zf});
            chk("latch", lat, port_latch_q);
            if (o[14:8] != `PORT_FILE_ADDR) begin
                apb(0, 12'h200 + {o[14:8], 2'b00}, 32'h0000_0000);
                chk("file", m[o[14:8]], rd);
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1;
        #1;
        chk("reset", 11'h000, {acc_q, cf, dcf, zf});
        for (i = 32; i < 40; i = i + 1) begin
            lf = nx(lf);
            m[i] = lf[7:0];
            apb(1, 12'h200 + 4 * i, {24'h00_0000, lf[7:0]});
        end
        apb(1, `OFS_ACC, 32'h0000_000f);
        acc = 8'h0f;
        exec(`OP_ADD_LIT, 19'h0_00f1);
        for (i = 0; i < 90; i = i + 1) begin
            lf = nx(lf);
            exec(i % 6 + 1, {lf[18:15], (lf[11] ? 7'h06 : {4'h4, lf[10:8]}), lf[7:0]});
        end
        apb(1, `OFS_COMMAND, 32'h0000_0000);
        apb(1, `OFS_COMMAND, 32'h0000_0007);
        #1;
        chk("spare codes", {acc, c, dc, z, lat}, {acc_q, cf, dcf, zf, port_latch_q});
        lf = nx(lf);
        apb(1, 12'h218, {24'h00_0000, lf[7:0]});
        lat = lf[7:0];
        #1;
        chk("latch slot", lat, port_latch_q);
        apb(0, `OFS_STATUS, 32'h0000_0000);
        chk("status", {z, dc, c}, rd);
        apb(0, `OFS_ACC, 32'h0000_0000);
        chk("acc read", acc, rd);
        chk("acc err", 32'h0000_0000, {31'h0000_0000, se});
        apb(0, 12'h014, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0000_0000, se});
        chk("unmapped data", 32'h0000_0000, rd);
        complete_run;
    end
endmodule // test_byte_alu_bit_ops
